// *** core/sews_consts.svh ***
`ifndef SEWS_CONSTS_SVH
`define SEWS_CONSTS_SVH

// ==========================================================================
// Opcodes (bit 3 of read and write carries the high address bit)
`define SEWS_OP_SET_LATCH 8'h06
`define SEWS_OP_CLR_LATCH 8'h04
`define SEWS_OP_STAT_RD 8'h05
`define SEWS_OP_STAT_WR 8'h01
`define SEWS_OP_RD_LOW 3'h3
`define SEWS_OP_WR_LOW 3'h2
`define SEWS_OP_ADDR_BIT 3

// ==========================================================================
// Status byte fields
`define SEWS_ST_BUSY 0
`define SEWS_ST_LATCH 1
`define SEWS_ST_PROT_LO 2
`define SEWS_ST_WDOG_LO 4

// ==========================================================================
// Timing in ms as printed; reference clock in Hz
`define SEWS_WRITE_MS 10
`define SEWS_HOLD_MS 200
`define SEWS_WDOG_SHORT_MS 200
`define SEWS_WDOG_MID_MS 600
`define SEWS_WDOG_LONG_MS 1400
`define SEWS_CLK_HZ 125000000
`define SEWS_CYC_PER_MS (`SEWS_CLK_HZ / 1000)

`endif

// *** core/sews_pkg.sv ***
package sews_pkg;
    typedef enum logic [2:0] {
        SEWS_OPC,
        SEWS_ADDR,
        SEWS_WDATA,
        SEWS_SDATA,
        SEWS_RDATA,
        SEWS_SREAD,
        SEWS_IGNORE
    } sews_phase_t;
endpackage

// *** core/sews_sync.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Two-stage level synchroniser
module sews_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Meta stage read only by second stage
    always_ff @(posedge clk_in) begin
        meta_q <= d_in;
        sync_q <= meta_q;
    end

    assign q_out = sync_q;
endmodule

// *** core/sews_timer.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Down counter; load starts it, done pulses when it expires
module sews_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    output logic busy_out,
    output logic done_out
);
    logic [WIDTH-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire last = busy_q && (cnt_q <= WIDTH'(1));

    // Count and expiry
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (load_in) begin
            cnt_q <= count_in;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            cnt_q <= busy_q ? cnt_q - WIDTH'(1) : cnt_q;
            busy_q <= busy_q && !last;
            done_q <= last;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
endmodule

// *** core/sews_supervisor.sv ***
`timescale 1ns/10ps
`include "sews_consts.svh"

// Operation
// - Write needs latch set by a complete set command ended by deselect.
// - Memory write is opcode, address, data, select low throughout; 24 clocks minimum.
// - Opcode bit 3 of read and write is the ninth address bit.
// - Page address wraps from low bits 11 back to 00, overwriting.
// - Write starts only if deselect after clock 24, 32, 40 or 48.
// - Status read works during write; busy bit reads 1, others undefined.
// - Reset output asserts on low supply or watchdog timeout; polarity per variant.
// - Opcode 06 sets the write latch, 04 clears it, no arguments.
// - Opcode 05 reads status; 01 writes protect and watchdog bits.
// - Read opcode low bits 011, write 010, upper nibble zero.
// - Opcodes and data move most significant bit first.
// - After power-up output is off, latch clear, select falling edge needed.
// - Write-protect low clears the write latch.
// - Nonvolatile write finishes within 10 ms of the ending deselect.
// - Watchdog codes 10, 01, 00 give 200 ms, 600 ms, 1.4 s.
// - Reset stays asserted 100 to 400 ms after its cause clears.
// - Status bits 5..0: watchdog select, protect level, latch, busy.
// - Protect 00 none, 01 top quarter, 10 upper half, 11 all.
// - Select falling edge restarts watchdog; code 11 disables it.
// - Latch clears when any write cycle completes.
module sews_supervisor #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int WRITE_CYCLES = `SEWS_WRITE_MS * `SEWS_CYC_PER_MS,
    parameter int HOLD_CYCLES = `SEWS_HOLD_MS * `SEWS_CYC_PER_MS,
    parameter int WDOG_SHORT_CYCLES = `SEWS_WDOG_SHORT_MS * `SEWS_CYC_PER_MS,
    parameter int WDOG_MID_CYCLES = `SEWS_WDOG_MID_MS * `SEWS_CYC_PER_MS,
    parameter int WDOG_LONG_CYCLES = `SEWS_WDOG_LONG_MS * `SEWS_CYC_PER_MS
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_si_in,
    input wire logic write_protect_n_in,
    input wire logic supply_low_in,
    output logic spi_so_out,
    output logic spi_so_oe_out,
    output logic sup_reset_out,
    output logic sup_reset_oe_out
);
    // ======================================================================
    // Link domain (serial clock): shifting and command decode
    sews_pkg::sews_phase_t phase_q;
    logic [7:0] mem_q [0:511];
    logic [6:0] sh_q;
    logic [2:0] bit_q;
    logic [5:0] clk_cnt_q;
    logic [7:0] op_q;
    logic [8:0] addr_q;
    logic [7:0] page_q [0:3];
    logic [3:0] page_v_q;
    logic [7:0] out_q;
    logic so_q;
    logic so_oe_q;
    logic wr_go_q;
    logic st_go_q;
    logic [3:0] st_new_q;
    logic set_tgl_q;
    logic clr_tgl_q;
    logic cmd_tgl_q;
    logic [8:0] wr_base_q;
    logic [3:0] wr_mask_q;
    logic [7:0] wr_data_q [0:3];
    logic [7:0] sh_last_q;
    logic wp_meta_q;
    logic wp_link_q;

    // Settled state seen from the link side, two stages deep
    logic [3:0] nv_m_q;
    logic latch_m_q;
    logic busy_m_q;
    logic [3:0] nv_q;
    logic latch_q;
    logic busy_q;

    wire [7:0] byte_in = {sh_q, spi_si_in};
    wire byte_done = (bit_q == 3'h7);
    wire [2:0] op_low = byte_in[2:0];
    wire op_is_rd = (byte_in[7:4] == 4'h0) && (op_low == `SEWS_OP_RD_LOW);
    wire op_is_wr = (byte_in[7:4] == 4'h0) && (op_low == `SEWS_OP_WR_LOW);
    wire [8:0] next_rd = addr_q + 9'h001;
    wire [7:0] status_byte = busy_q ? 8'hff :
        {2'b00, nv_q[3:2], nv_q[1:0], latch_q, 1'b0};

    // Protected range test by level code
    function automatic logic is_protected(input logic [1:0] lvl, input logic [8:0] a);
        case (lvl)
            2'h1: is_protected = (a[8:7] == 2'h3);
            2'h2: is_protected = a[8];
            2'h3: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    // Input shift, bit count, frame clock count, MSB first
    always_ff @(posedge spi_sck_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            sh_q <= 7'h00;
            bit_q <= 3'h0;
            clk_cnt_q <= 6'h00;
        end else begin
            sh_q <= byte_in[6:0];
            bit_q <= bit_q + 3'h1;
            clk_cnt_q <= (clk_cnt_q == 6'h3f) ? clk_cnt_q : clk_cnt_q + 6'h01;
        end
    end

    // Command phase machine
    always_ff @(posedge spi_sck_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            phase_q <= sews_pkg::SEWS_OPC;
        end else if (byte_done) begin
            case (phase_q)
                sews_pkg::SEWS_OPC: begin
                    if (op_is_rd || op_is_wr) begin
                        op_q <= byte_in;
                        addr_q[8] <= byte_in[`SEWS_OP_ADDR_BIT];
                        phase_q <= sews_pkg::SEWS_ADDR;
                    end else if (byte_in == `SEWS_OP_STAT_RD) begin
                        phase_q <= sews_pkg::SEWS_SREAD;
                    end else if (byte_in == `SEWS_OP_STAT_WR) begin
                        phase_q <= sews_pkg::SEWS_SDATA;
                    end else begin
                        phase_q <= sews_pkg::SEWS_IGNORE;
                    end
                end
                sews_pkg::SEWS_ADDR: begin
                    addr_q[7:0] <= byte_in;
                    phase_q <= (op_q[2:0] == `SEWS_OP_RD_LOW) ?
                        sews_pkg::SEWS_RDATA : sews_pkg::SEWS_WDATA;
                end
                sews_pkg::SEWS_WDATA: begin
                    addr_q[1:0] <= addr_q[1:0] + 2'h1;
                end
                sews_pkg::SEWS_RDATA: begin
                    addr_q <= next_rd;
                end
                sews_pkg::SEWS_SDATA: phase_q <= sews_pkg::SEWS_IGNORE;
                default: phase_q <= phase_q;
            endcase
        end
    end

    // Page buffer: reloaded at each write, later bytes overwrite on wrap
    always_ff @(posedge spi_sck_in) begin
        if (!spi_cs_n_in && byte_done && phase_q == sews_pkg::SEWS_ADDR) begin
            page_v_q <= 4'h0;
        end else if (!spi_cs_n_in && byte_done && phase_q == sews_pkg::SEWS_WDATA) begin
            page_q[addr_q[1:0]] <= byte_in;
            page_v_q[addr_q[1:0]] <= 1'b1;
        end
    end

    // Output data, shifted out on the falling edge, MSB first
    always_ff @(negedge spi_sck_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            so_oe_q <= 1'b0;
            so_q <= 1'b0;
            out_q <= 8'h00;
        end else if (bit_q == 3'h0 && phase_q == sews_pkg::SEWS_SREAD) begin
            so_oe_q <= 1'b1;
            so_q <= status_byte[7];
            out_q <= {status_byte[6:0], 1'b0};
        end else if (bit_q == 3'h0 && phase_q == sews_pkg::SEWS_RDATA) begin
            so_oe_q <= 1'b1;
            so_q <= mem_q[addr_q][7];
            out_q <= {mem_q[addr_q][6:0], 1'b0};
        end else begin
            so_q <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    // Deselect ends the frame: decide on a write and post events
    wire wr_count_ok = (clk_cnt_q == 6'h18) || (clk_cnt_q == 6'h20) ||
        (clk_cnt_q == 6'h28) || (clk_cnt_q == 6'h30);
    wire set_ok = (clk_cnt_q == 6'h08) && (sh_last_q == `SEWS_OP_SET_LATCH);
    wire clr_ok = (clk_cnt_q == 6'h08) && (sh_last_q == `SEWS_OP_CLR_LATCH);

    // First byte of the frame kept for deselect-time decisions
    always_ff @(posedge spi_sck_in) begin
        if (!spi_cs_n_in && byte_done && phase_q == sews_pkg::SEWS_OPC) begin
            sh_last_q <= byte_in;
        end
    end

    // Write-protect and latch qualify writes at frame end
    wire wp_ok = wp_link_q;
    wire mem_wr_ok = (phase_q == sews_pkg::SEWS_WDATA) && wr_count_ok && latch_q &&
        wp_ok && !busy_q && !is_protected(nv_q[1:0], addr_q);
    wire st_wr_ok = (phase_q == sews_pkg::SEWS_IGNORE) && (clk_cnt_q == 6'd16) &&
        (sh_last_q == `SEWS_OP_STAT_WR) && latch_q && wp_ok && !busy_q;

    // Write-protect pin through two stages on the serial clock
    always_ff @(posedge spi_sck_in) begin
        wp_meta_q <= write_protect_n_in;
        wp_link_q <= wp_meta_q;
        if (phase_q == sews_pkg::SEWS_SDATA && byte_done) begin
            st_new_q <= byte_in[5:2];
        end
    end

    // Write image captured at deselect, stable until the commit
    always_ff @(posedge spi_cs_n_in) begin
        if (mem_wr_ok) begin
            wr_base_q <= addr_q;
            wr_mask_q <= page_v_q;
            for (int i = 0; i < 4; i++) begin
                wr_data_q[i] <= page_q[i];
            end
        end
    end

    // Event toggles raised at deselect; cleared so both sides start equal
    always_ff @(posedge spi_cs_n_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_go_q <= 1'b0;
            st_go_q <= 1'b0;
            set_tgl_q <= 1'b0;
            clr_tgl_q <= 1'b0;
        end else begin
            if (mem_wr_ok) begin
                wr_go_q <= !wr_go_q;
            end
            if (st_wr_ok) begin
                st_go_q <= !st_go_q;
            end
            if (set_ok && !busy_q) begin
                set_tgl_q <= !set_tgl_q;
            end
            if (clr_ok) begin
                clr_tgl_q <= !clr_tgl_q;
            end
        end
    end

    // Select falling edge toggles a kick event
    always_ff @(negedge spi_cs_n_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_tgl_q <= 1'b0;
        end else begin
            cmd_tgl_q <= !cmd_tgl_q;
        end
    end

    // ======================================================================
    // Reference domain: latch, busy, nonvolatile array, watchdog, reset
    logic [4:0] ev_s;
    logic [4:0] ev_prev_q;
    logic wp_s;
    logic [3:0] nv_r_q;
    logic latch_r_q;
    logic busy_r_q;
    logic st_pend_q;
    logic hold_q;
    logic sup_rst_q;

    sews_sync #(.WIDTH(6)) u_sync (
        .clk_in(ref_clk_in),
        .d_in({wr_go_q, st_go_q, set_tgl_q, clr_tgl_q, cmd_tgl_q,
            write_protect_n_in}),
        .q_out({ev_s, wp_s})
    );

    wire [4:0] ev_pulse = ev_s ^ ev_prev_q;
    wire wr_start = ev_pulse[4] || ev_pulse[3];
    wire wr_done;
    wire wr_busy;
    wire wd_done;
    wire hold_done;
    wire hold_busy;
    wire wd_off = (nv_r_q[3:2] == 2'h3);
    wire [31:0] wd_len = (nv_r_q[3:2] == 2'h2) ? 32'(WDOG_SHORT_CYCLES) :
        (nv_r_q[3:2] == 2'h1) ? 32'(WDOG_MID_CYCLES) : 32'(WDOG_LONG_CYCLES);
    wire cause = supply_low_in || (wd_done && !wd_off);
    // Hold time starts on a cause, or once after reset when nothing runs
    wire hold_load = cause || (hold_q && !hold_busy && !hold_done);
    // Watchdog restarts at a select fall, or as the hold time ends
    wire hold_end = hold_q && hold_done && !cause;
    wire wd_kick = hold_end || (ev_pulse[0] && !hold_q);

    // Nonvolatile write cycle duration
    sews_timer #(.WIDTH(32)) u_write_timer (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .load_in(wr_start),
        .count_in(32'(WRITE_CYCLES)),
        .busy_out(wr_busy),
        .done_out(wr_done)
    );

    // Watchdog and reset hold share one counter
    sews_timer #(.WIDTH(32)) u_wdog_timer (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .load_in(hold_load || wd_kick),
        .count_in(hold_load ? 32'(HOLD_CYCLES) : wd_len),
        .busy_out(hold_busy),
        .done_out(hold_done)
    );
    assign wd_done = hold_done && !hold_q;

    // Latch, busy and status bits commit
    always_ff @(posedge ref_clk_in) begin
        ev_prev_q <= ev_s;
        if (!reset_n_in) begin
            latch_r_q <= 1'b0;
            busy_r_q <= 1'b0;
            nv_r_q <= 4'h0;
        end else begin
            busy_r_q <= wr_start || (wr_busy && !wr_done);
            if (!wp_s || wr_done) begin
                latch_r_q <= 1'b0;
            end else if (ev_pulse[2]) begin
                latch_r_q <= 1'b1;
            end else if (ev_pulse[1]) begin
                latch_r_q <= 1'b0;
            end
            if (wr_done && st_pend_q) begin
                nv_r_q <= st_new_q;
            end
        end
    end

    // Status write pending for commit; stays clear for a memory write
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            st_pend_q <= 1'b0;
        end else if (ev_pulse[3]) begin
            st_pend_q <= 1'b1;
        end else if (wr_done) begin
            st_pend_q <= 1'b0;
        end
    end

    // Array written at completion; words stable while busy
    always_ff @(posedge ref_clk_in) begin
        if (wr_done && !st_pend_q) begin
            for (int i = 0; i < 4; i++) begin
                if (wr_mask_q[i]) begin
                    mem_q[{wr_base_q[8:2], 2'(i)}] <= wr_data_q[i];
                end
            end
        end
    end

    // Reset output: held asserted through cause and hold time
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            hold_q <= 1'b1;
            sup_rst_q <= 1'b1;
        end else begin
            hold_q <= cause || (hold_q && !(hold_done && !cause));
            sup_rst_q <= cause || (hold_q && !(hold_done && !cause));
        end
    end

    // Link-side copies of settled state, two stages
    always_ff @(posedge spi_sck_in) begin
        nv_m_q <= nv_r_q;
        latch_m_q <= latch_r_q;
        busy_m_q <= busy_r_q;
        nv_q <= nv_m_q;
        latch_q <= latch_m_q;
        busy_q <= busy_m_q;
    end

    assign spi_so_out = so_q;
    assign spi_so_oe_out = so_oe_q;
    assign sup_reset_out = sup_rst_q ^ !RESET_ACTIVE_HIGH;
    assign sup_reset_oe_out = sup_rst_q;
endmodule

// *** tb/sews_supervisor_checker.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Port-level checks of the serial memory supervisor
module sews_supervisor_checker #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int HOLD_CYCLES = 200
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_si_in,
    input wire logic write_protect_n_in,
    input wire logic supply_low_in,
    input wire logic spi_so_out,
    input wire logic spi_so_oe_out,
    input wire logic sup_reset_out,
    input wire logic sup_reset_oe_out
);
    logic sck_q;
    logic [5:0] cnt_q;
    logic [7:0] op_q;
    logic [31:0] hold_q;

    // Opcode classes seen on the wire
    wire sck_rise = spi_sck_in && !sck_q;
    wire op_wr = op_q[7:4] == 4'h0 && op_q[2:0] == 3'h2;
    wire op_rd = op_q[7:4] == 4'h0 && op_q[2:0] == 3'h3;
    wire op_quiet = op_q == 8'h06 || op_q == 8'h04 || op_q == 8'h01 || op_wr;
    wire op_known = op_quiet || op_rd || op_q == 8'h05;

    // Clock count and opcode of the current frame
    always_ff @(posedge ref_clk_in) begin
        sck_q <= spi_sck_in;
        if (!reset_n_in || spi_cs_n_in) begin
            cnt_q <= 6'h00;
            op_q <= 8'h00;
        end else if (sck_rise && cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q < 6'h08) begin
                op_q <= {op_q[6:0], spi_si_in};
            end
        end
    end

    // Cycles since the reset cause went away
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || supply_low_in || !sup_reset_oe_out) begin
            hold_q <= 32'h0;
        end else begin
            hold_q <= hold_q + 32'h1;
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    so_off_desel_a: assert property (spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_so_oe_out)
        else $error("serial output driven while deselected");
    unknown_op_quiet_a: assert property (
        !spi_cs_n_in && cnt_q >= 6'h08 && !op_known |-> !spi_so_oe_out)
        else $error("serial output driven after unknown opcode");
    cmd_no_output_a: assert property (
        !spi_cs_n_in && cnt_q >= 6'h08 && op_quiet |-> !spi_so_oe_out)
        else $error("serial output driven during a command without reply");
    status_drive_a: assert property (
        !spi_cs_n_in && cnt_q >= 6'h0a && op_q == 8'h05 |-> spi_so_oe_out)
        else $error("status byte not driven");
    read_drive_a: assert property (!spi_cs_n_in && cnt_q >= 6'h12 && op_rd |-> spi_so_oe_out)
        else $error("read data not driven");
    reset_level_a: assert property (sup_reset_oe_out |-> sup_reset_out == RESET_ACTIVE_HIGH)
        else $error("reset output has wrong level");
    supply_trip_a: assert property (supply_low_in [*6] |-> sup_reset_oe_out)
        else $error("low supply did not assert reset");
    hold_time_a: assert property ($fell(sup_reset_oe_out) |->
        hold_q >= HOLD_CYCLES - 4 && hold_q <= HOLD_CYCLES + 10)
        else $error("reset released at wrong time");
endmodule

bind sews_supervisor sews_supervisor_checker #(
    .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH),
    .HOLD_CYCLES(HOLD_CYCLES)
) checker_u (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .spi_sck_in(spi_sck_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_si_in(spi_si_in),
    .write_protect_n_in(write_protect_n_in),
    .supply_low_in(supply_low_in),
    .spi_so_out(spi_so_out),
    .spi_so_oe_out(spi_so_oe_out),
    .sup_reset_out(sup_reset_out),
    .sup_reset_oe_out(sup_reset_oe_out)
);

// *** tb/sews_host_model.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Serial bus controller in the host's place
module sews_host_model (
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out
);
    localparam time HALF = 16;
    logic so_last;
    logic so_seen;

    // Released output line shows the inverse of its last level
    always @(so_in or so_oe_in) begin
        if (so_oe_in) begin
            so_last = so_in;
        end
    end
    assign so_seen = so_oe_in ? so_in : ~so_last;

    // Clock idles low between frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // One frame of nbits, data out on falling, sampled on rising
    task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = 64'h0;
        cs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_out = tx[i];
            #(HALF);
            sck_out = 1'b1;
            rx = {rx[62:0], so_seen};
            #(HALF);
            sck_out = 1'b0;
        end
        #(HALF);
        cs_n_out = 1'b1;
        si_out = ~si_out;
        #(HALF * 26);
    endtask
endmodule

// *** tb/sews_supervisor_test.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the serial memory supervisor
module sews_supervisor_test;
    localparam int HOLD = 200;
    logic ref_clk, reset_n, wp_n, supply_low;
    logic sck, cs_n, si, so, so_oe, rst_out, rst_oe;
    int num_errors = 0;
    int num_checks = 0;

    sews_supervisor #(
        .RESET_ACTIVE_HIGH(1'b0),
        .WRITE_CYCLES(100),
        .HOLD_CYCLES(HOLD),
        .WDOG_SHORT_CYCLES(300),
        .WDOG_MID_CYCLES(600),
        .WDOG_LONG_CYCLES(1000)
    ) dut_u (
        .ref_clk_in(ref_clk), .reset_n_in(reset_n), .spi_sck_in(sck),
        .spi_cs_n_in(cs_n), .spi_si_in(si), .write_protect_n_in(wp_n),
        .supply_low_in(supply_low), .spi_so_out(so), .spi_so_oe_out(so_oe),
        .sup_reset_out(rst_out), .sup_reset_oe_out(rst_oe)
    );

    sews_host_model host_u (
        .so_in(so), .so_oe_in(so_oe), .sck_out(sck), .cs_n_out(cs_n), .si_out(si)
    );

    // Reference clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ======================================================================
    // Helper tasks
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        @(negedge ref_clk);
        #2;
        host_u.frame(tx, n, rx);
    endtask

    task automatic status(output logic [31:0] st);
        logic [63:0] rx;
        xfer({48'h0, 8'h05, 8'h00}, 16, rx);
        st = {24'h0, rx[7:0]};
    endtask

    task automatic wait_idle(output logic [31:0] st);
        st = 32'h1;
        for (int i = 0; i < 8 && st[0] !== 1'b0; i++) status(st);
        check("busy_end", st & 32'h1, 32'h0);
    endtask

    task automatic wait_level(input logic lvl, output int n);
        n = 0;
        while (rst_oe !== lvl && n < 1500) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic do_write(input logic [7:0] op, input logic [7:0] adr,
                            input logic [31:0] data, input int nb);
        logic [63:0] rx;
        logic [31:0] st;
        xfer(64'h06, 8, rx);
        xfer({16'h0, op, adr, data} >> (8 * (4 - nb)), 16 + 8 * nb, rx);
        wait_idle(st);
        check("latch_end", st & 32'h2, 32'h0);
    endtask

    // Cut a hung run short
    initial begin
        #(400us);
        num_errors++;
        end_of_test();
    end

    // ======================================================================
    // Main sequence
    initial begin
        int n;
        logic [31:0] st;
        logic [63:0] rx;
        static int counts[6] = '{24, 32, 40, 48, 25, 39};
        static logic [63:0] stream = {8'h02, 8'h20, 48'h0102_0304_0506};
        reset_n = 1'b0;
        wp_n = 1'b1;
        supply_low = 1'b0;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        check("rst_level", {30'h0, rst_oe, rst_out}, 32'h2);
        wait_level(1'b0, n);
        check("hold_boot", {31'h0, n >= HOLD - 4 && n <= HOLD + 10}, 32'h1);
        status(st);
        check("st_boot", st & 32'h3f, 32'h0);
        // Set and clear the latch
        xfer(64'h06, 8, rx);
        status(st);
        check("latch_set", st & 32'h3, 32'h2);
        xfer(64'h04, 8, rx);
        status(st);
        check("latch_clr", st & 32'h3, 32'h0);
        // Write chained after set without deselect, then with latch clear
        xfer({32'h0, 8'h06, 8'h02, 8'h00, 8'h5a}, 32, rx);
        status(st);
        check("chain_wr", st & 32'h1, 32'h0);
        xfer(64'h04, 8, rx);
        xfer({40'h0, 8'h02, 8'h10, 8'ha5}, 24, rx);
        status(st);
        check("nolatch_wr", st & 32'h1, 32'h0);
        // Write protect low drops the latch and blocks the write
        xfer(64'h06, 8, rx);
        @(negedge ref_clk);
        wp_n = 1'b0;
        status(st);
        check("wp_latch", st & 32'h2, 32'h0);
        xfer({40'h0, 8'h02, 8'h10, 8'ha5}, 24, rx);
        status(st);
        check("wp_wr", st & 32'h1, 32'h0);
        @(negedge ref_clk);
        wp_n = 1'b1;
        // Deselect at legal and illegal clock counts
        foreach (counts[i]) begin
            xfer(64'h06, 8, rx);
            xfer(stream >> (64 - counts[i]), counts[i], rx);
            status(st);
            check("busy_go", st & 32'h1, {31'h0, counts[i] % 8 == 0});
            wait_idle(st);
            check("latch_left", st & 32'h2, {30'h0, counts[i] % 8 != 0, 1'b0});
        end
        // Page wrap in the upper half, then a two-byte write without wrap in the lower half
        do_write(8'h0a, 8'h02, 32'h11223344, 4);
        do_write(8'h02, 8'h02, 32'h55660000, 2);
        xfer({16'h0, 8'h0b, 8'h00, 32'h0}, 48, rx);
        check("rd_hi", rx[31:0], 32'h33441122);
        xfer({32'h0, 8'h03, 8'h02, 16'h0}, 32, rx);
        check("rd_lo", {16'h0, rx[15:0]}, 32'h5566);
        // Protect all, short watchdog
        do_write(8'h01, 8'h2c, 32'h0, 0);
        status(st);
        check("st_prog", st & 32'h3f, 32'h2c);
        xfer(64'h06, 8, rx);
        xfer({40'h0, 8'h02, 8'h00, 8'h77}, 24, rx);
        status(st);
        check("prot_wr", st & 32'h1, 32'h0);
        repeat (150) @(negedge ref_clk);
        check("wdog_early", {31'h0, rst_oe}, 32'h0);
        wait_level(1'b1, n);
        check("wdog_fire", {31'h0, n < 200}, 32'h1);
        wait_level(1'b0, n);
        check("hold_wdog", {31'h0, n >= HOLD - 4 && n <= HOLD + 10}, 32'h1);
        // Watchdog off, nothing protected
        do_write(8'h01, 8'h30, 32'h0, 0);
        status(st);
        check("st_off", st & 32'h3f, 32'h30);
        repeat (1200) @(negedge ref_clk);
        check("wdog_off", {31'h0, rst_oe}, 32'h0);
        // Supply trip
        supply_low = 1'b1;
        repeat (10) @(negedge ref_clk);
        check("supply_rst", {30'h0, rst_oe, rst_out}, 32'h2);
        supply_low = 1'b0;
        wait_level(1'b0, n);
        check("hold_supply", {31'h0, n >= HOLD - 4 && n <= HOLD + 10}, 32'h1);
        // Unknown opcode leaves state alone
        xfer({48'h0, 8'hff, 8'h00}, 16, rx);
        status(st);
        check("unknown_op", st & 32'h3f, 32'h30);
        end_of_test();
    end
endmodule
